// ### rtl/mcar_avg.sv
// Sample window counter for single-shot average auto refresh.
// Assumes sample pulses last one clock.
module mcar_avg (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] len,
    input  wire logic       sample,
    input  wire logic       clr,
    output logic            done
);
    logic [7:0] cnt_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (clr) begin
                cnt_q <= 8'h00;
            end else if (sample) begin
                if (cnt_q + 8'h01 >= len) begin
                    cnt_q <= 8'h00;
                    done  <= 1'b1; // RL9
                end else begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
        end
    end
endmodule

// ### rtl/mcar_pin.sv
// One multifunction pin: synchroniser, function decode and done pulse.
// Assumes alert level and done event come from logic on the same clock.
module mcar_pin
    import mcar_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] fn,
    input  wire logic       alert_lvl,
    input  wire logic       cc_evt,
    input  wire logic       cc_en,
    input  wire logic       gpio_out,
    input  wire logic       pin_i,
    output logic            pin_o,
    output logic            pin_oe,
    output logic            pin_lvl,
    output logic            slow_hi
);
    logic       s1_q;
    logic       s2_q;
    logic [8:0] cc_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
        end
    end

    // Done pulse, only in alert function
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cc_q <= 9'h000;
        end else if (cc_evt && cc_en && fn == FN_ALERT) begin
            cc_q <= 9'(CC_PULSE_CYC); // RL19
        end else if (cc_q != 9'h000) begin
            cc_q <= cc_q - 9'h001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_o  <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_oe <= (fn == FN_ALERT) || (fn == FN_GOUT); // RL1
            if (fn == FN_GOUT)
                pin_o <= gpio_out; // RL5
            else
                pin_o <= (fn == FN_ALERT) && (alert_lvl || cc_q != 9'h000); // RL18
        end
    end

    assign pin_lvl = s2_q;
    assign slow_hi = (fn == FN_SLOW) && s2_q; // RL3

    property p_cc_pulse;
        @(posedge clk) disable iff (!rst_n)
        cc_evt && cc_en && fn == FN_ALERT ##1 fn == FN_ALERT |=> pin_o && pin_oe;
    endproperty
    a_cc_pulse: assert property (p_cc_pulse) // RL19
        else $error("done pulse not driven");

    property p_no_drive;
        @(posedge clk) disable iff (!rst_n)
        fn == FN_SLOW || fn == FN_GIN |=> !pin_oe;
    endproperty
    a_no_drive: assert property (p_no_drive) // RL18
        else $error("pin driven outside output function");
endmodule

// ### rtl/mcar_pkg.sv
// Shared constants, field layouts and helpers for the monitor config block.
// Assumes a single 50 MHz clock and a register port driven by the bus slave.
//
// Contract
// [RL1] Pin one select: alert, gpio in, out, slow
// [RL2] Pin zero select bits 9:8, same codes
// [RL3] Slow pin high forces 8 sps mode
// [RL4] Slow function overrides every other sample setting
// [RL5] GPIO pin data held in bus settings
// [RL6] Average code selects rolling length, two reserved
// [RL7] Adaptive accumulation active only while slow high
// [RL8] Accumulator source: power, sense or bus
// [RL9] Auto refresh after each conversion cycle
// [RL10] Manual refresh ignored while auto refresh on
// [RL11] Auto modes: off, clear refresh, keep refresh
// [RL12] Host disables auto refresh before config changes
// [RL13] Active range image, upper nibble zero
// [RL14] Sense range codes: unipolar, bipolar, half
// [RL15] Bus range codes: unipolar, bipolar, half
// [RL16] Pin zero routing enables, unused bits zero
// [RL17] Routing writes wait for next refresh
// [RL18] Routing drives pin only in alert function
// [RL19] Conversion done pulse high for 5 us
// [RL20] Full alerts fire on overflow or limit
// [RL21] Host enables alerts before routing them
// [RL22] Config staged, activated by manual refresh only
// [RL23] Pending copy written, active copy loaded
package mcar_pkg;
    // ****************
    // Register map
    // ****************
    localparam logic [7:0] A_CTRL      = 8'h01;
    localparam logic [7:0] A_RANGE     = 8'h03;
    localparam logic [7:0] A_GPIO      = 8'h04;
    localparam logic [7:0] A_CTRL_ACT  = 8'h17;
    localparam logic [7:0] A_RANGE_ACT = 8'h18;
    localparam logic [7:0] A_ROUTE     = 8'h19;

    typedef struct packed {
        logic [3:0] smode;
        logic [1:0] fn1;
        logic [1:0] fn0;
        logic [2:0] avg;
        logic       aa;
        logic [1:0] src;
        logic [1:0] auto_rf;
    } mcar_ctrl_t;

    typedef struct packed {
        logic [1:0] vs;
        logic [1:0] vb;
    } mcar_range_t;

    localparam logic [15:0] CTRL_RST   = 16'h2520;
    localparam logic [3:0]  RANGE_RST  = 4'h0;
    localparam logic [15:0] ROUTE_RST  = 16'h0000;
    localparam logic [15:0] ROUTE_MASK = 16'h3ffe;
    localparam int          ROUTE_CC   = 1;

    typedef enum logic [1:0] {
        FN_ALERT = 2'h0,
        FN_GIN   = 2'h1,
        FN_GOUT  = 2'h2,
        FN_SLOW  = 2'h3
    } mcar_fn_t;

    localparam logic [1:0] AR_OFF  = 2'h0;
    localparam logic [1:0] AR_LIM  = 2'h1;
    localparam logic [1:0] AR_LIMV = 2'h2;
    localparam logic [1:0] RK_V    = 2'h1;
    localparam logic [3:0] SMODE_SLOW   = 4'h5;
    localparam logic [3:0] SMODE_SS_AVG = 4'h7;

    // ****************
    // Timing
    // ****************
    localparam int CLK_MHZ      = 50;
    localparam int CC_PULSE_NS  = 5000;
    localparam int CC_PULSE_CYC = CC_PULSE_NS * CLK_MHZ / 1000;

    // Rolling average length, reserved codes fall back to 8
    function automatic logic [7:0] avg_len(input logic [2:0] code);
        case (code)
            3'h0: avg_len = 8'h04;
            3'h1: avg_len = 8'h08;
            3'h2: avg_len = 8'h10;
            3'h3: avg_len = 8'h20;
            3'h5: avg_len = 8'h40;
            3'h7: avg_len = 8'h80;
            default: avg_len = 8'h08;
        endcase
    endfunction
endpackage

// ### rtl/mcar_top.sv
// Config staging, range image and alert routing of the power monitor.
// Assumes a bus slave decodes host transfers into the register port,
// and that the converter and accumulator report events on this clock.
module mcar_top
    import mcar_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic [15:0]      reg_rdata,
    input  wire logic        refresh_req,
    input  wire logic [1:0]  refresh_kind,
    input  wire logic        conv_done,
    input  wire logic        sample_done,
    input  wire logic [9:0]  limit_alerts,
    input  wire logic        accumulator_full_route,
    input  wire logic        acc_at_limit,
    input  wire logic        cnt_ovf,
    input  wire logic        cnt_at_limit,
    input  wire logic        pin0_i,
    output logic             pin0_o,
    output logic             pin0_oe,
    input  wire logic        pin1_i,
    output logic             pin1_o,
    output logic             pin1_oe,
    output logic [3:0]       sample_mode,
    output logic             slow_active,
    output logic             adapt_accum,
    output logic [1:0]       acc_source,
    output logic [2:0]       avg_code,
    output logic [1:0]       sense_range,
    output logic [1:0]       bus_range,
    output logic             refresh_pulse,
    output logic             accum_clear
);
    // ****************
    // Reset release
    // ****************
    logic rs1_q;
    logic rst_s_n;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rs1_q   <= 1'b0;
            rst_s_n <= 1'b0;
        end else begin
            rs1_q   <= 1'b1;
            rst_s_n <= rs1_q;
        end
    end

    // ****************
    // Declarations
    // ****************
    mcar_ctrl_t  ctrl_pend_q;
    mcar_ctrl_t  ctrl_act_q;
    mcar_range_t range_pend_q;
    mcar_range_t range_act_q;
    logic [15:0] route_pend_q;
    logic [15:0] route_act_q;
    logic [1:0]  gpio_out_q;
    logic        auto_on;
    logic        man_exec;
    logic        auto_exec;
    logic        win_done;
    logic        man_clear;
    logic        auto_clear;
    logic [15:0] alert_vec;
    logic        alert0_lvl;
    logic        pin0_lvl;
    logic        pin1_lvl;
    logic        slow0_hi;
    logic        slow1_hi;
    logic        slow_any;
    logic [15:0] rdata_d;

    // ****************
    // Refresh control
    // ****************
    // Auto field takes hold at once, so the host can leave auto mode
    assign auto_on = ctrl_pend_q.auto_rf != AR_OFF;

    assign man_exec = refresh_req && !auto_on; // RL10

    assign auto_exec = auto_on &&
        ((ctrl_act_q.smode == SMODE_SS_AVG) ? win_done : conv_done); // RL9

    assign man_clear = man_exec && refresh_kind != RK_V;

    assign auto_clear = auto_exec && ctrl_pend_q.auto_rf == AR_LIM; // RL11

    mcar_avg u_avg (
        .clk    (sys_clk),
        .rst_n  (rst_s_n),
        .len    (avg_len(ctrl_act_q.avg)), // RL6
        .sample (sample_done),
        .clr    (refresh_pulse),
        .done   (win_done)
    );

    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            refresh_pulse <= 1'b0;
            accum_clear   <= 1'b0;
        end else begin
            refresh_pulse <= man_exec || auto_exec;
            accum_clear   <= man_clear || auto_clear; // RL11
        end
    end

    // ****************
    // Control staging
    // ****************
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            ctrl_pend_q <= CTRL_RST;
        end else if (reg_wr && reg_addr == A_CTRL) begin
            ctrl_pend_q <= reg_wdata; // RL23
        end
    end

    // Limited refreshes never activate pending settings
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            ctrl_act_q <= CTRL_RST;
        end else if (man_exec) begin
            ctrl_act_q <= ctrl_pend_q; // RL22
        end
    end

    // ****************
    // Range staging
    // ****************
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            range_pend_q <= RANGE_RST;
        end else if (reg_wr && reg_addr == A_RANGE) begin
            range_pend_q <= reg_wdata[3:0]; // RL23
        end
    end

    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            range_act_q <= RANGE_RST;
        end else if (man_exec) begin
            range_act_q <= range_pend_q; // RL13
        end
    end

    // ****************
    // Alert routing
    // ****************
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            route_pend_q <= ROUTE_RST;
        end else if (reg_wr && reg_addr == A_ROUTE) begin
            route_pend_q <= reg_wdata & ROUTE_MASK; // RL16
        end
    end

    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            route_act_q <= ROUTE_RST;
        end else if (man_exec) begin
            route_act_q <= route_pend_q; // RL17
        end
    end

    // Full alerts fire on wrap or on reaching the set limit
    assign alert_vec = {2'h0, limit_alerts,
                        accumulator_full_route || acc_at_limit,
                        cnt_ovf || cnt_at_limit, 2'h0}; // RL20

    assign alert0_lvl = |(alert_vec & route_act_q);

    // ****************
    // GPIO data
    // ****************
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            gpio_out_q <= 2'b00;
        end else if (reg_wr && reg_addr == A_GPIO) begin
            gpio_out_q <= reg_wdata[1:0]; // RL5
        end
    end

    // ****************
    // Pins
    // ****************
    mcar_pin u_pin0 (
        .clk       (sys_clk),
        .rst_n     (rst_s_n),
        .fn        (ctrl_act_q.fn0), // RL2
        .alert_lvl (alert0_lvl),
        .cc_evt    (conv_done),
        .cc_en     (route_act_q[ROUTE_CC]), // RL19
        .gpio_out  (gpio_out_q[0]),
        .pin_i     (pin0_i),
        .pin_o     (pin0_o),
        .pin_oe    (pin0_oe),
        .pin_lvl   (pin0_lvl),
        .slow_hi   (slow0_hi)
    );

    // Second pin has no routing here, so it only idles low as alert
    mcar_pin u_pin1 (
        .clk       (sys_clk),
        .rst_n     (rst_s_n),
        .fn        (ctrl_act_q.fn1), // RL1
        .alert_lvl (1'b0),
        .cc_evt    (conv_done),
        .cc_en     (1'b0),
        .gpio_out  (gpio_out_q[1]),
        .pin_i     (pin1_i),
        .pin_o     (pin1_o),
        .pin_oe    (pin1_oe),
        .pin_lvl   (pin1_lvl),
        .slow_hi   (slow1_hi)
    );

    assign slow_any = slow0_hi || slow1_hi;

    // ****************
    // Active settings out
    // ****************
    // Slow override beats every mode, triggered ones included
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            sample_mode <= CTRL_RST[15:12];
            slow_active <= 1'b0;
            adapt_accum <= 1'b0;
        end else begin
            sample_mode <= slow_any ? SMODE_SLOW : ctrl_act_q.smode; // RL3 RL4
            slow_active <= slow_any; // RL3
            adapt_accum <= slow_any && ctrl_act_q.aa; // RL7
        end
    end

    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            acc_source  <= CTRL_RST[3:2];
            avg_code    <= CTRL_RST[7:5];
            sense_range <= RANGE_RST[3:2];
            bus_range   <= RANGE_RST[1:0];
        end else begin
            acc_source  <= ctrl_act_q.src; // RL8
            avg_code    <= ctrl_act_q.avg; // RL6
            sense_range <= range_act_q.vs; // RL14
            bus_range   <= range_act_q.vb; // RL15
        end
    end

    // ****************
    // Read mux
    // ****************
    always_comb begin
        rdata_d = 16'h0000;
        case (reg_addr)
            A_CTRL:      rdata_d = ctrl_pend_q;
            A_CTRL_ACT:  rdata_d = {ctrl_act_q[15:2], ctrl_pend_q.auto_rf};
            A_RANGE:     rdata_d = {12'h000, range_pend_q};
            A_RANGE_ACT: rdata_d = {12'h000, range_act_q}; // RL13
            A_ROUTE:     rdata_d = route_pend_q; // RL16
            A_GPIO:      rdata_d = {14'h0,
                             (ctrl_act_q.fn1 == FN_GIN) ? pin1_lvl : gpio_out_q[1],
                             (ctrl_act_q.fn0 == FN_GIN) ? pin0_lvl : gpio_out_q[0]};
            default:     rdata_d = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end
    end

    // ****************
    // Checks
    // ****************
    property p_manual_ignored;
        @(posedge sys_clk) disable iff (!rst_s_n)
        auto_on && refresh_req |=> $stable(ctrl_act_q) && $stable(route_act_q);
    endproperty
    a_manual_ignored: assert property (p_manual_ignored) // RL10
        else $error("manual refresh acted in auto mode");

    property p_route_held;
        @(posedge sys_clk) disable iff (!rst_s_n)
        !man_exec |=> $stable(route_act_q);
    endproperty
    a_route_held: assert property (p_route_held) // RL17
        else $error("routing changed without refresh");

    property p_activate;
        @(posedge sys_clk) disable iff (!rst_s_n)
        man_exec |=> ctrl_act_q == $past(ctrl_pend_q) && refresh_pulse;
    endproperty
    a_activate: assert property (p_activate) // RL22
        else $error("refresh did not activate settings");

    property p_range_image;
        @(posedge sys_clk) disable iff (!rst_s_n)
        reg_rd && reg_addr == A_RANGE_ACT |=> reg_rdata[15:4] == 12'h000;
    endproperty
    a_range_image: assert property (p_range_image) // RL13
        else $error("range image upper bits set");

    property p_route_bits;
        @(posedge sys_clk) disable iff (!rst_s_n)
        reg_rd && reg_addr == A_ROUTE |=> reg_rdata[15:14] == 2'b00 && !reg_rdata[0];
    endproperty
    a_route_bits: assert property (p_route_bits) // RL16
        else $error("routing unused bits set");

    property p_slow_mode;
        @(posedge sys_clk) disable iff (!rst_s_n)
        slow_any |=> slow_active && sample_mode == SMODE_SLOW;
    endproperty
    a_slow_mode: assert property (p_slow_mode) // RL3
        else $error("slow pin did not force 8 sps");

    property p_adapt;
        @(posedge sys_clk) disable iff (!rst_s_n)
        adapt_accum |-> slow_active;
    endproperty
    a_adapt: assert property (p_adapt) // RL7
        else $error("adaptive accumulation without slow");

    property p_keep_refresh;
        @(posedge sys_clk) disable iff (!rst_s_n)
        auto_exec && ctrl_pend_q.auto_rf == AR_LIMV |=> refresh_pulse && !accum_clear;
    endproperty
    a_keep_refresh: assert property (p_keep_refresh) // RL11
        else $error("keep refresh cleared accumulator");
endmodule

// ### test/mcar_host.sv
// Host controller model: register writes, reads and refresh commands.
// Assumes the bench calls its tasks; all changes land on falling edges.
module mcar_host (
    input  wire logic        sys_clk,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [7:0]       reg_addr,
    output logic [15:0]      reg_wdata,
    output logic             refresh_req,
    output logic [1:0]       refresh_kind
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        refresh_req = 1'b0;
        refresh_kind = 2'h0;
    end

    // Callers keep auto refresh off around config writes
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    // Extra idle cycle so read data settles before the next access
    task automatic rd(input logic [7:0] a);
        @(negedge sys_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge sys_clk);
    endtask

    task automatic refresh(input logic [1:0] k);
        @(negedge sys_clk);
        refresh_req = 1'b1;
        refresh_kind = k;
        @(negedge sys_clk);
        refresh_req = 1'b0;
        refresh_kind = ~k;
    endtask
endmodule

// ### test/monitor_config_alert_routing_test.sv
// Self-checking bench for the monitor config and alert routing block.
// Assumes the host model drives the register port and refresh commands.
module monitor_config_alert_routing_test
    import mcar_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic        sys_clk, rst_n, conv_done, sample_done, pin0_i, pin1_i;
    logic [9:0]  limit_alerts;
    logic [3:0]  ev;
    logic        reg_wr, reg_rd, refresh_req;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, r, c, g;
    logic [1:0]  refresh_kind, acc_source, sense_range, bus_range;
    logic        pin0_o, pin0_oe, pin1_o, pin1_oe, slow_active, adapt_accum;
    logic        refresh_pulse, accum_clear, rd_p1, rd_p2;
    logic [3:0]  sample_mode;
    logic [2:0]  avg_code;
    logic [2:0]  codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
    logic [15:0] exp_q [$];
    int          fails, checked, seed, n, n_pulse, n_clr, bp, bc;

    mcar_host host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .refresh_req(refresh_req),
        .refresh_kind(refresh_kind));

    mcar_top DUT (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .refresh_req(refresh_req), .refresh_kind(refresh_kind), .conv_done(conv_done),
        .sample_done(sample_done), .limit_alerts(limit_alerts), .accumulator_full_route(ev[0]),
        .acc_at_limit(ev[1]), .cnt_ovf(ev[2]), .cnt_at_limit(ev[3]),
        .pin0_i(pin0_i), .pin0_o(pin0_o), .pin0_oe(pin0_oe), .pin1_i(pin1_i),
        .pin1_o(pin1_o), .pin1_oe(pin1_oe), .sample_mode(sample_mode),
        .slow_active(slow_active), .adapt_accum(adapt_accum), .acc_source(acc_source),
        .avg_code(avg_code), .sense_range(sense_range), .bus_range(bus_range),
        .refresh_pulse(refresh_pulse), .accum_clear(accum_clear));

    // ****************
    // Clock and monitor
    // ****************
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    initial begin
        rd_p1 = 1'b0;
        rd_p2 = 1'b0;
    end

    always @(posedge sys_clk) begin
        rd_p1 <= reg_rd;
        rd_p2 <= rd_p1;
    end

    always @(negedge sys_clk) begin
        if (refresh_pulse === 1'b1) n_pulse <= n_pulse + 1;
        if (accum_clear === 1'b1) n_clr <= n_clr + 1;
        if (rd_p2 === 1'b1) cmp_rd(reg_rdata);
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] e, input string what);
        checked++;
        if (got !== e) begin
            fails++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, e);
        end
    endtask

    task automatic cmp_rd(input logic [15:0] got);
        logic [15:0] e;
        e = 'x;
        if (exp_q.size() > 0) e = exp_q.pop_front();
        chk(got, e, "read data");
    endtask

    task automatic rdx(input logic [7:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask

    task automatic since(input int ep, input int ec);
        chk(16'(n_pulse - bp), 16'(ep), "refresh count");
        chk(16'(n_clr - bc), 16'(ec), "clear count");
        bp = n_pulse;
        bc = n_clr;
    endtask

    task automatic rf(input logic [1:0] k, input int e);
        bp = n_pulse;
        bc = n_clr;
        host.refresh(k);
        cyc(3);
        since(e, (e == 1 && k != 2'h1) ? 1 : 0);
    endtask

    task automatic pulse_conv;
        @(negedge sys_clk);
        conv_done = 1'b1;
        @(negedge sys_clk);
        conv_done = 1'b0;
    endtask

    task automatic print_verdict;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        fails++;
        $display("[ERR] %0t run limit reached", $time);
        print_verdict();
    end

    // ****************
    // Scenarios
    // ****************
    initial begin
        seed = 26078;
        rst_n = 1'b0;
        conv_done = 1'b0;
        sample_done = 1'b0;
        pin0_i = 1'b0;
        pin1_i = 1'b1;
        limit_alerts = 10'h000;
        ev = 4'h0;
        cyc(10);
        rst_n = 1'b1;
        cyc(3);
        rdx(A_CTRL, CTRL_RST);
        rdx(A_CTRL_ACT, CTRL_RST);
        rdx(A_RANGE_ACT, 16'h0000);
        rdx(A_ROUTE, ROUTE_RST);
        rdx(A_GPIO, 16'h0002);
        rdx(8'h7f, 16'h0000);
        $display("test reset done");

        r = 16'($random(seed));
        host.wr(A_ROUTE, r);
        rdx(A_ROUTE, r & ROUTE_MASK);
        host.wr(A_RANGE, 16'h0009);
        host.wr(A_RANGE_ACT, 16'h00ff);
        rdx(A_RANGE_ACT, 16'h0000);
        rf(2'h0, 1);
        rdx(A_RANGE_ACT, 16'h0009);
        for (int i = 0; i < 6; i++) begin
            c = {4'h2, 2'h1, 2'h1, codes[i], 1'b0, 2'(i % 3), 2'h0};
            g = {12'h0, 2'(i % 3), 2'((i + 1) % 3)};
            host.wr(A_CTRL, c);
            host.wr(A_RANGE, g);
            rf(2'(i % 3), 1);
            chk(16'(avg_code), 16'(codes[i]), "avg code");
            chk(16'(acc_source), 16'(i % 3), "acc source");
            chk(16'({sense_range, bus_range}), g, "ranges");
            rdx(A_CTRL_ACT, c);
            rdx(A_RANGE_ACT, g);
        end
        $display("test staging done");

        host.wr(A_ROUTE, 16'h0000);
        host.wr(A_CTRL, 16'h2020);
        rf(2'h0, 1);
        host.wr(A_ROUTE, 16'h200c);
        limit_alerts = 10'h200;
        cyc(4);
        chk(16'(pin0_o), 16'h0, "route pending");
        rf(2'h1, 1);
        chk(16'({pin1_oe, pin1_o, pin0_oe, pin0_o}), 16'hb, "route live");
        limit_alerts = 10'h100;
        cyc(4);
        chk(16'(pin0_o), 16'h0, "unrouted alert");
        limit_alerts = 10'h000;
        for (int i = 0; i < 4; i++) begin
            ev = 4'h1 << i;
            cyc(4);
            chk(16'(pin0_o), 16'h1, "full alert");
        end
        ev = 4'h0;
        host.wr(A_ROUTE, 16'h0002);
        rf(2'h2, 1);
        pulse_conv();
        n = 0;
        repeat (300) begin
            @(negedge sys_clk);
            if (pin0_o === 1'b1) n++;
        end
        chk(16'(n), 16'(CC_PULSE_CYC), "done pulse width");
        host.wr(A_CTRL, 16'h2520);
        rf(2'h0, 1);
        chk(16'({pin1_oe, pin0_oe}), 16'h0, "input pin idle");
        $display("test alert done");

        pin1_i = 1'b0;
        host.wr(A_CTRL, 16'hcf30);
        rf(2'h0, 1);
        pin0_i = 1'b1;
        cyc(5);
        chk(16'(sample_mode), 16'(SMODE_SLOW), "slow mode");
        chk(16'({slow_active, adapt_accum, pin0_oe}), 16'h6, "slow flags");
        pin0_i = 1'b0;
        cyc(5);
        chk(16'(sample_mode), 16'hc, "mode back");
        chk(16'({slow_active, adapt_accum}), 16'h0, "slow off");
        pin1_i = 1'b1;
        cyc(5);
        chk(16'({slow_active, sample_mode}), 16'h15, "slow on pin one");
        host.wr(A_CTRL, 16'h2920);
        rf(2'h0, 1);
        host.wr(A_GPIO, 16'h0002);
        pin0_i = 1'b1;
        cyc(4);
        chk(16'({pin1_oe, pin1_o}), 16'h3, "gpio out");
        rdx(A_GPIO, 16'h0003);
        $display("test pins done");

        host.wr(A_RANGE, 16'h0005);
        host.wr(A_CTRL, 16'h2922);
        rf(2'h0, 0);
        pulse_conv();
        cyc(3);
        since(1, 0);
        host.wr(A_CTRL, 16'h2920);
        host.wr(A_CTRL, 16'h2921);
        pulse_conv();
        cyc(3);
        since(1, 1);
        rdx(A_RANGE_ACT, g);
        host.wr(A_CTRL, 16'h2920);
        host.wr(A_CTRL, 16'h7500);
        rf(2'h0, 1);
        host.wr(A_CTRL, 16'h7501);
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk);
            sample_done = 1'b1;
            @(negedge sys_clk);
            sample_done = 1'b0;
            cyc(3);
            since((i == 3) ? 1 : 0, (i == 3) ? 1 : 0);
        end
        $display("test auto refresh done");
        print_verdict();
    end
endmodule
